// ---- design/shr_pkg.sv ----
// Purpose: Shared constants and types for the scanner command responder.
// Assumes: 25 MHz logic clock, fixed character rate on the serial link.
// Notes:   Opcodes and response codes without a printed value are arbitrary.
package shr_pkg;

   // Clock and character timing
   localparam int unsigned CLK_HZ        = 25_000_000;
   // Rate is a free choice; a fast one keeps each exchange short
   localparam int unsigned BAUD_RATE     = 500_000;
   localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
   localparam int unsigned CHAR_BITS     = 11;
   localparam int unsigned CHAR_CYCLES   = BIT_CYCLES * CHAR_BITS;
   localparam logic [11:0] BIT_RELOAD    = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALF_BIT      = 12'(BIT_CYCLES / 2);
   localparam logic [3:0]  LAST_BIT      = 4'hA;

   // Gap must exceed one character; counted from mid stop bit, hence one bit more
   localparam int unsigned GAP_CYCLES    = CHAR_CYCLES + BIT_CYCLES;
   // Silence inside a frame that ends it as short
   localparam int unsigned IDLE_CYCLES   = 2 * CHAR_CYCLES;
   // Clear must be answered in under 5 s; leave room for the reply itself
   localparam int unsigned CLEAR_LIMIT_MS = 5000;
   localparam int unsigned ACK_LIMIT_MS   = 500;
   localparam int unsigned CLEAR_CYCLES  = CLEAR_LIMIT_MS * (CLK_HZ / 1000) - 1;
   localparam int unsigned CLEAR_WAIT_CYCLES = CLEAR_CYCLES - 5 * CHAR_CYCLES;

   // Frame bytes
   localparam logic [7:0] ACK_BYTE       = 8'hFF;
   localparam logic [7:0] MIN_LEN        = 8'h02;
   localparam logic [7:0] MAX_LEN        = 8'h20;
   localparam logic [1:0] RSP_LEN_SHORT  = 2'h2;
   localparam logic [1:0] RSP_LEN_LONG   = 2'h3;

   // Command opcodes
   localparam logic [7:0] OP_CLEAR       = 8'h44;
   localparam logic [7:0] OP_CONTROL     = 8'h58;
   localparam logic [7:0] OP_START       = 8'h53;
   localparam logic [7:0] OP_READ        = 8'h5A;
   localparam logic [7:0] OP_SENSE       = 8'h42;
   localparam logic [7:0] OP_RET_SENSE   = 8'h43; // Arbitrary value
   localparam logic [7:0] OP_IMG_SETUP   = 8'h49; // Arbitrary value
   localparam logic [7:0] OP_IMG_QUERY   = 8'h4D; // Arbitrary value
   localparam logic [7:0] OP_INQUIRY     = 8'h51; // Arbitrary value
   localparam logic [7:0] OP_DITHER      = 8'h57; // Arbitrary value
   localparam logic [7:0] OP_PRINT       = 8'h50; // Arbitrary value
   localparam logic [7:0] OP_DATA_SEND   = 8'h4C; // Arbitrary value

   // Response codes
   localparam logic [7:0] RC_READY       = 8'h52;
   localparam logic [7:0] RC_NORMAL      = 8'h4E;
   localparam logic [7:0] RC_READ_DONE   = 8'h46;
   localparam logic [7:0] RC_IMG_STATUS  = 8'h49; // Arbitrary value
   localparam logic [7:0] RC_UNIT_STATUS = 8'h4A; // Arbitrary value
   localparam logic [7:0] RC_OP_ERR      = 8'h55;
   localparam logic [7:0] RC_TEMP_ERR    = 8'h54;
   localparam logic [7:0] RC_EQP_ERR     = 8'h50;

   // Detail byte of an operation error
   localparam logic [7:0] DET_XMIT       = 8'h01;
   localparam logic [7:0] DET_SEQ        = 8'h02;
   localparam logic [7:0] DET_UNKNOWN    = 8'h04;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_GAP_ACK   = 3'b001,
      ST_SEND_ACK  = 3'b010,
      ST_EXEC      = 3'b011,
      ST_GAP_RSP   = 3'b100,
      ST_SEND_RSP  = 3'b101,
      ST_WAIT_HACK = 3'b110
   } shr_state_t;

endpackage

// ---- design/shr_char_link.sv ----
// Purpose: Character transmitter and receiver with start, even parity and stop.
// Assumes: Serial input already synchronous to clk; LSB first.
// Notes:   A bad stop bit is reported as a parity fault.
module shr_char_link (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ser_in,
   output logic            ser_out,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_perr
);
   import shr_pkg::*;

   typedef struct packed {
      logic        tx_busy;
      logic [3:0]  tx_bit;
      logic [11:0] tx_cnt;
      logic [9:0]  tx_sh;
      logic        ser_out_n;
      logic        rx_busy;
      logic [3:0]  rx_bit;
      logic [11:0] rx_cnt;
      logic [9:0]  rx_sh;
      logic        rx_valid;
      logic [7:0]  rx_data;
      logic        rx_perr;
   } shr_link_st_t;

   shr_link_st_t q;
   shr_link_st_t n;

   // Next state of both directions
   always_comb begin
      logic [9:0] sh_in;
      sh_in = {ser_in, q.rx_sh[9:1]};
      n = q;
      n.rx_valid = 1'b0;
      // Transmit: start bit, then data, parity and stop from the shifter
      if (!q.tx_busy) begin
         if (tx_valid) begin
            n.tx_busy   = 1'b1;
            n.tx_bit    = 4'h0;
            n.tx_cnt    = BIT_RELOAD;
            n.tx_sh     = {1'b1, ^tx_data, tx_data};
            n.ser_out_n = 1'b1;
         end
      end else if (q.tx_cnt != 12'h000) begin
         n.tx_cnt = q.tx_cnt - 12'h001;
      end else if (q.tx_bit == LAST_BIT) begin
         n.tx_busy = 1'b0;
      end else begin
         n.ser_out_n = ~q.tx_sh[0];
         n.tx_sh     = {1'b1, q.tx_sh[9:1]};
         n.tx_bit    = q.tx_bit + 4'h1;
         n.tx_cnt    = BIT_RELOAD;
      end
      // Receive: sample mid-bit; a short low glitch is not a start bit
      if (!q.rx_busy) begin
         if (!ser_in) begin
            n.rx_busy = 1'b1;
            n.rx_bit  = 4'h0;
            n.rx_cnt  = HALF_BIT;
         end
      end else if (q.rx_cnt != 12'h000) begin
         n.rx_cnt = q.rx_cnt - 12'h001;
      end else if (q.rx_bit == 4'h0 && ser_in) begin
         n.rx_busy = 1'b0;
      end else begin
         n.rx_sh  = sh_in;
         n.rx_bit = q.rx_bit + 4'h1;
         n.rx_cnt = BIT_RELOAD;
         // Stop bit is the last sample, so the shifter holds data, parity, stop
         if (q.rx_bit == LAST_BIT) begin
            n.rx_busy  = 1'b0;
            n.rx_valid = 1'b1;
            n.rx_data  = sh_in[7:0];
            n.rx_perr  = (^sh_in[8:0]) | ~sh_in[9];
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign ser_out  = ~q.ser_out_n; // Line idles high
   assign tx_ready = ~q.tx_busy;
   assign rx_valid = q.rx_valid;
   assign rx_data  = q.rx_data;
   assign rx_perr  = q.rx_perr;

endmodule

// ---- design/shr_cmd_responder.sv ----
// Purpose: Scanner side of the host command link: frames, acks, one response per command.
// Assumes: Mechanics report init, read and fault status on plain level inputs.
// Notes:   Response payloads beyond code and detail byte are not produced.
// Notes on behaviour
// [RULE1] Clear answers ready after init, equipment error on init fault.
// [RULE2] Control, image setup, dither: normal status, or operation error if discarded.
// [RULE3] Start and read give temporary error on jam, empty hopper, cover open.
// [RULE4] Read answers read-complete, or equipment error on read fault.
// [RULE5] Out-of-order or corrupted sequence commands get operation error.
// [RULE6] Sense: temporary error while jammed, else normal status.
// [RULE7] Sense family returns equipment error once a fault was reported; return sense after a clear fault gets operation error instead.
// [RULE8] Return sense answers normal status when fault free.
// [RULE9] Image query, inquiry, print, data send get their own normal answers.
// [RULE10] Clear is 03 44 00; ready reply is 02 52.
// [RULE11] Control opcode 58; normal status code 4E.
// [RULE12] Host sends start as two bytes, opcode 53.
// [RULE13] Read opcode 5A; read-complete code 46.
// [RULE14] Host sends sense as two bytes, opcode 42.
// [RULE15] Every frame is acknowledged with one FF byte.
// [RULE16] Clear acked under 500 ms, answered under 5 s.
// [RULE17] More than one character time before ack or response.
// [RULE18] DTR held low while a clear executes.
// [RULE19] RTS low except while sending read-complete.
// [RULE20] Characters carry start, parity and stop bits.
// [RULE21] Error responses are three bytes: code 55, 54 or 50, then detail.
// [RULE22] Control between duplex front read and back start is ignored.
// [RULE23] First frame byte holds total length and delimits the frame.
// [RULE24] Parity or length faults count as transmission errors.
module shr_cmd_responder #(
   parameter int unsigned GAP_CYC   = shr_pkg::GAP_CYCLES,
   parameter int unsigned IDLE_CYC  = shr_pkg::IDLE_CYCLES,
   parameter int unsigned CLEAR_CYC = shr_pkg::CLEAR_WAIT_CYCLES
) (
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic       RXD,
   output logic            TXD,
   output logic            DTR,
   output logic            RTS,
   input  wire logic       SCAN_DUPLEX,
   input  wire logic       JAM,
   input  wire logic       HOPPER_EMPTY,
   input  wire logic       COVER_OPEN,
   output logic            INIT_START,
   input  wire logic       INIT_DONE,
   input  wire logic       INIT_FAULT,
   output logic            READ_START,
   input  wire logic       READ_DONE,
   input  wire logic       READ_FAULT,
   input  wire logic [7:0] FAULT_DETAIL,
   output logic            CMD_STROBE,
   output logic [7:0]      CMD_OPCODE
);
   import shr_pkg::*;

   typedef struct packed {
      shr_state_t  st;
      logic [26:0] tmr;
      logic [7:0]  rx_idx;
      logic [7:0]  rx_len;
      logic [7:0]  rx_op;
      logic        rx_bad;
      logic        exec_pend;
      logic        is_clear;
      logic [7:0]  rsp_code;
      logic [7:0]  rsp_det;
      logic [1:0]  rsp_len;
      logic [1:0]  tx_idx;
      logic        ready;
      logic        started;
      logic        hold;
      logic        back;
      logic        fault;
      logic        init_go;
      logic        read_go;
      logic        cmd_stb;
      logic [7:0]  cmd_op;
      logic        rts;
      logic        dtr_low;
   } shr_top_st_t;

   shr_top_st_t q;
   shr_top_st_t n;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_ready;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        rx_perr;
   logic        frame_end;
   logic        frame_bad;
   logic [7:0]  op_now;
   logic        temp_cond;

   // [RULE20] framed characters
   shr_char_link u_link (
      .clk      (CLK),
      .rst_n    (RESETN),
      .ser_in   (RXD),
      .ser_out  (TXD),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_ready (tx_ready),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .rx_perr  (rx_perr)
   );

   assign op_now    = (q.rx_idx == 8'h01) ? rx_data : q.rx_op;
   assign temp_cond = JAM | HOPPER_EMPTY | COVER_OPEN;

   // Whole command/response sequencer
   always_comb begin
      n = q;
      n.init_go = 1'b0;
      n.read_go = 1'b0;
      n.cmd_stb = 1'b0;
      frame_end = 1'b0;
      frame_bad = 1'b0;
      tx_valid  = 1'b0;
      tx_data   = ACK_BYTE;
      case (q.st)
         ST_IDLE: begin
            if (q.rx_idx != 8'h00) begin
               n.tmr = q.tmr + 27'h1;
            end
            // [RULE23] length byte delimits
            if (rx_valid) begin
               n.tmr    = '0;
               n.rx_idx = q.rx_idx + 8'h01;
               if (q.rx_idx == 8'h00) begin
                  n.rx_len  = rx_data;
                  n.rx_bad  = rx_perr | (rx_data < MIN_LEN) | (rx_data > MAX_LEN);
                  frame_end = rx_data < MIN_LEN;
               end else begin
                  n.rx_bad  = q.rx_bad | rx_perr;
                  frame_end = (q.rx_idx + 8'h01) == q.rx_len;
                  if (q.rx_idx == 8'h01) begin
                     n.rx_op = rx_data;
                  end
               end
               frame_bad = n.rx_bad;
            // [RULE24] short frame times out
            end else if (q.rx_idx != 8'h00 && q.tmr >= 27'(IDLE_CYC)) begin
               frame_end = 1'b1;
               frame_bad = 1'b1;
            end
            if (frame_end) begin
               n.st        = ST_GAP_ACK;
               n.tmr       = '0;
               n.rx_idx    = 8'h00;
               n.exec_pend = 1'b0;
               n.is_clear  = 1'b0;
               n.rsp_code  = RC_NORMAL;
               n.rsp_det   = 8'h00;
               // [RULE24] transmission error reply
               if (frame_bad) begin
                  n.rsp_code = RC_OP_ERR;
                  n.rsp_det  = DET_XMIT;
               end else begin
                  case (op_now)
                     // [RULE1] clear runs init
                     OP_CLEAR: begin
                        n.exec_pend = 1'b1;
                        n.is_clear  = 1'b1;
                     end
                     // [RULE2] [RULE11] [RULE22] setup commands
                     OP_CONTROL, OP_IMG_SETUP, OP_DITHER: begin
                        if (q.hold && op_now == OP_CONTROL) begin
                           n.rsp_code = RC_OP_ERR;
                           n.rsp_det  = DET_SEQ;
                        end else begin
                           n.cmd_stb = 1'b1;
                           n.cmd_op  = op_now;
                        end
                     end
                     // [RULE3] [RULE5] start checks
                     OP_START: begin
                        if (!q.ready) begin
                           n.rsp_code = RC_OP_ERR;
                           n.rsp_det  = DET_SEQ;
                        end else if (temp_cond) begin
                           n.rsp_code = RC_TEMP_ERR;
                           n.rsp_det  = {5'h00, COVER_OPEN, HOPPER_EMPTY, JAM};
                        end else begin
                           n.started = 1'b1;
                           n.back    = q.hold;
                           n.hold    = 1'b0;
                           n.cmd_stb = 1'b1;
                           n.cmd_op  = op_now;
                        end
                     end
                     // [RULE3] [RULE4] [RULE5] read checks
                     OP_READ: begin
                        if (!q.started) begin
                           n.rsp_code = RC_OP_ERR;
                           n.rsp_det  = DET_SEQ;
                        end else if (temp_cond) begin
                           n.rsp_code = RC_TEMP_ERR;
                           n.rsp_det  = {5'h00, COVER_OPEN, HOPPER_EMPTY, JAM};
                        end else begin
                           n.exec_pend = 1'b1;
                        end
                     end
                     // [RULE6] [RULE7] sense
                     OP_SENSE: begin
                        if (q.fault) begin
                           n.rsp_code = RC_EQP_ERR;
                           n.rsp_det  = FAULT_DETAIL;
                        end else if (JAM) begin
                           n.rsp_code = RC_TEMP_ERR;
                           n.rsp_det  = {5'h00, COVER_OPEN, HOPPER_EMPTY, JAM};
                        end
                     end
                     // [RULE5] [RULE7] [RULE8] [RULE9] queries
                     OP_RET_SENSE, OP_IMG_QUERY: begin
                        if (!q.ready) begin
                           n.rsp_code = RC_OP_ERR;
                           n.rsp_det  = DET_SEQ;
                        end else if (q.fault) begin
                           n.rsp_code = RC_EQP_ERR;
                           n.rsp_det  = FAULT_DETAIL;
                        end else if (op_now == OP_IMG_QUERY) begin
                           n.rsp_code = RC_IMG_STATUS;
                        end
                     end
                     // [RULE9] unit status
                     OP_INQUIRY: n.rsp_code = RC_UNIT_STATUS;
                     // [RULE5] [RULE9] printer and data
                     OP_PRINT, OP_DATA_SEND: begin
                        if (!q.ready) begin
                           n.rsp_code = RC_OP_ERR;
                           n.rsp_det  = DET_SEQ;
                        end else begin
                           n.cmd_stb = 1'b1;
                           n.cmd_op  = op_now;
                        end
                     end
                     default: begin
                        n.rsp_code = RC_OP_ERR;
                        n.rsp_det  = DET_UNKNOWN;
                     end
                  endcase
               end
            end
         end
         // [RULE17] gap before ack
         ST_GAP_ACK: begin
            n.tmr = q.tmr + 27'h1;
            if (q.tmr >= 27'(GAP_CYC)) begin
               n.st = ST_SEND_ACK;
            end
         end
         // [RULE15] [RULE16] ack byte
         ST_SEND_ACK: begin
            if (tx_ready) begin
               tx_valid  = 1'b1;
               n.tmr     = '0;
               n.st      = q.exec_pend ? ST_EXEC : ST_GAP_RSP;
               n.init_go = q.exec_pend & q.is_clear;
               n.read_go = q.exec_pend & ~q.is_clear;
            end
         end
         // [RULE1] [RULE4] [RULE16] wait mechanics
         ST_EXEC: begin
            n.tmr = q.tmr + 27'h1;
            if (q.is_clear) begin
               if (INIT_FAULT || q.tmr >= 27'(CLEAR_CYC)) begin
                  n.st       = ST_GAP_RSP;
                  n.rsp_code = RC_EQP_ERR;
                  n.rsp_det  = FAULT_DETAIL;
                  n.fault    = 1'b1;
                  n.ready    = 1'b0;
               end else if (INIT_DONE) begin
                  n.st       = ST_GAP_RSP;
                  n.rsp_code = RC_READY;
                  n.ready    = 1'b1;
                  n.fault    = 1'b0;
               end
               // Clear aborts any scan sequence
               n.started = 1'b0;
               n.hold    = 1'b0;
               n.back    = 1'b0;
            end else if (READ_FAULT) begin
               n.st       = ST_GAP_RSP;
               n.rsp_code = RC_EQP_ERR;
               n.rsp_det  = FAULT_DETAIL;
               n.fault    = 1'b1;
               n.started  = 1'b0;
            end else if (READ_DONE) begin
               n.st       = ST_GAP_RSP;
               n.rsp_code = RC_READ_DONE;
               n.started  = 1'b0;
               // [RULE22] duplex front done
               n.hold     = SCAN_DUPLEX & ~q.back;
               n.back     = 1'b0;
            end
            if (n.st == ST_GAP_RSP) begin
               n.tmr = '0;
            end
         end
         // [RULE17] gap counted once the ack has ended and any execution is done
         ST_GAP_RSP: begin
            n.tmr = tx_ready ? q.tmr + 27'h1 : '0;
            if (tx_ready && q.tmr >= 27'(GAP_CYC)) begin
               n.st     = ST_SEND_RSP;
               n.tx_idx = 2'h0;
            end
         end
         // [RULE10] [RULE13] [RULE21] response bytes
         ST_SEND_RSP: begin
            case (q.tx_idx)
               2'h0:    tx_data = {6'h00, q.rsp_len};
               2'h1:    tx_data = q.rsp_code;
               default: tx_data = q.rsp_det;
            endcase
            if (tx_ready) begin
               if (q.tx_idx != q.rsp_len) begin
                  tx_valid = 1'b1;
                  n.tx_idx = q.tx_idx + 2'h1;
               end else begin
                  n.st = ST_WAIT_HACK;
               end
            end
         end
         // [RULE15] host ack
         ST_WAIT_HACK: begin
            if (rx_valid && !rx_perr && rx_data == ACK_BYTE) begin
               n.st  = ST_IDLE;
               n.tmr = '0;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // [RULE21] error frames carry a detail byte
      n.rsp_len = (n.rsp_code == RC_OP_ERR || n.rsp_code == RC_TEMP_ERR || n.rsp_code == RC_EQP_ERR)
                  ? RSP_LEN_LONG : RSP_LEN_SHORT;
      // [RULE19] [RULE18] modem lines
      n.rts     = (n.st == ST_SEND_RSP) && (n.rsp_code == RC_READ_DONE);
      n.dtr_low = (n.st == ST_EXEC) && n.is_clear;
   end

   // State register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign DTR        = ~q.dtr_low;
   assign RTS        = q.rts;
   assign INIT_START = q.init_go;
   assign READ_START = q.read_go;
   assign CMD_STROBE = q.cmd_stb;
   assign CMD_OPCODE = q.cmd_op;

   // Checks on the sequencer
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_bad_end;
      frame_end && frame_bad;
   endsequence
   sequence s_good_op(logic [7:0] op);
      frame_end && !frame_bad && op_now == op;
   endsequence

   a_rts_read_done: assert property (RTS |-> q.rsp_code == RC_READ_DONE && q.st == ST_SEND_RSP) // [RULE19]
      else $error("RTS high outside read complete");
   a_dtr_clear_low: assert property (q.st == ST_EXEC && q.is_clear |-> !DTR) // [RULE18]
      else $error("DTR high during clear");
   a_clear_bound: assert property (q.st == ST_EXEC && q.is_clear |-> q.tmr <= 27'(CLEAR_CYC)) // [RULE16]
      else $error("clear wait exceeded limit");
   a_ack_value: assert property (tx_valid && q.st == ST_SEND_ACK |-> tx_data == ACK_BYTE) // [RULE15]
      else $error("ack byte not FF");
   a_gap_before_ack: assert property ($rose(q.st == ST_SEND_ACK) |-> $past(q.tmr) >= 27'(GAP_CYC)) // [RULE17]
      else $error("ack sent without character gap");
   a_err_three_bytes: assert property (q.st == ST_SEND_RSP && q.rsp_code == RC_TEMP_ERR |-> q.rsp_len == 2'h3) // [RULE21]
      else $error("error response not three bytes");
   a_bad_frame_op: assert property (s_bad_end |=> q.rsp_code == RC_OP_ERR && q.rsp_det == DET_XMIT) // [RULE24]
      else $error("corrupt frame not answered as operation error");
   a_start_temp_err: assert property (s_good_op(OP_START) and (q.ready && temp_cond)
                                      |=> q.rsp_code == RC_TEMP_ERR && !q.started) // [RULE3]
      else $error("blocked start not temporary error");
   a_sense_fault: assert property (s_good_op(OP_SENSE) and q.fault |=> q.rsp_code == RC_EQP_ERR) // [RULE7]
      else $error("sense missed reported fault");
   a_clear_ready: assert property (q.st == ST_EXEC && q.is_clear && INIT_DONE && !INIT_FAULT
                                   && q.tmr < 27'(CLEAR_CYC)
                                   |=> q.rsp_code == RC_READY && q.st == ST_GAP_RSP ##1 DTR) // [RULE1]
      else $error("clear did not answer ready");

endmodule

// ---- verif/shr_host_model.sv ----
// Purpose: Host side of the serial command link, sends and receives characters.
// Assumes: Package bit time, even parity, LSB first, line idle high.
// Notes:   Bit time taken from the package so both ends agree.
module shr_host_model
   import shr_pkg::*;
(
   input  wire logic CLK,
   output logic      RXD,
   input  wire logic TXD
);
   timeunit 1ns;
   timeprecision 1ns;
   initial RXD = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         RXD <= f[i];
         repeat (BIT_CYCLES) @(posedge CLK);
      end
   endtask
   // Bounded wait for a start bit, then mid-bit sampling; n is idle time seen
   task automatic get_byte(output logic [7:0] b, output logic ok, output int n);
      logic [10:0] f;
      n = 0;
      while (TXD !== 1'b0 && n < 400000) begin
         @(posedge CLK);
         n++;
      end
      repeat (HALF_BIT) @(posedge CLK);
      for (int i = 0; i < 11; i++) begin
         f[i] = TXD;
         if (i < 10) repeat (BIT_CYCLES) @(posedge CLK);
      end
      b = f[8:1];
      ok = (n < 400000) && (f[0] === 1'b0) && (f[10] === 1'b1) && (^f[9:1] === 1'b0);
      repeat (HALF_BIT) @(posedge CLK);
   endtask
endmodule

// ---- verif/shr_cmd_responder_tb.sv ----
// Purpose: Self-checking bench for the scanner command responder.
// Assumes: Real character rate, so each exchange takes many thousand cycles.
// Notes:   Mechanics inputs are driven by the bench as levels.
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module shr_cmd_responder_tb
   import shr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       CLK = 1'b0, RESETN = 1'b0, JAM = 1'b0, INIT_DONE = 1'b0, INIT_FAULT = 1'b0;
   logic       SCAN_DUPLEX = 1'b0, HOPPER_EMPTY = 1'b0, COVER_OPEN = 1'b0;
   logic       READ_DONE = 1'b0, READ_FAULT = 1'b0;
   logic [7:0] FAULT_DETAIL = 8'h00;
   logic       RXD, TXD, DTR, RTS, ok, INIT_START, READ_START, CMD_STROBE;
   logic [7:0] b, CMD_OPCODE;
   int         n, err_count = 0, n_tests = 0, pulses = 0;
   // Clock at 25 MHz
   always #20 CLK = ~CLK;
   shr_cmd_responder #(.CLEAR_CYC(2000)) i_shr_cmd_responder (.CLK(CLK), .RESETN(RESETN), .RXD(RXD),
      .TXD(TXD), .DTR(DTR), .RTS(RTS), .SCAN_DUPLEX(SCAN_DUPLEX), .JAM(JAM), .HOPPER_EMPTY(HOPPER_EMPTY),
      .COVER_OPEN(COVER_OPEN), .INIT_START(INIT_START), .INIT_DONE(INIT_DONE), .INIT_FAULT(INIT_FAULT),
      .READ_START(READ_START), .READ_DONE(READ_DONE), .READ_FAULT(READ_FAULT), .FAULT_DETAIL(FAULT_DETAIL),
      .CMD_STROBE(CMD_STROBE), .CMD_OPCODE(CMD_OPCODE));
   shr_host_model i_shr_host_model (.CLK(CLK), .RXD(RXD), .TXD(TXD));
   // Count every one-cycle start and strobe pulse
   always @(posedge CLK) pulses <= pulses + INIT_START + READ_START + CMD_STROBE;
   // Receive one byte and compare it
   task automatic expect_byte(input logic [7:0] e);
      i_shr_host_model.get_byte(b, ok, n);
      `CHK("byte", e, b)
      `CHK("framing", 1'b1, ok)
   endtask
   // Command frame out, ack back after more than one character of silence
   task automatic send_cmd(input logic [7:0] len, input logic [7:0] op);
      i_shr_host_model.send_byte(len);
      i_shr_host_model.send_byte(op);
      if (len == 8'h03) i_shr_host_model.send_byte(8'h00);
      expect_byte(ACK_BYTE);
      `CHK("ack gap", 1'b1, n > int'(CHAR_CYCLES))
   endtask
   // Host acknowledges a response after a character of silence
   task automatic host_ack();
      repeat (CHAR_CYCLES + 1) @(posedge CLK);
      i_shr_host_model.send_byte(ACK_BYTE);
   endtask
   // Clear: DTR low while executing, then ready frame
   task automatic t_clear();
      send_cmd(8'h03, OP_CLEAR);
      repeat (BIT_CYCLES) @(posedge CLK);
      `CHK("dtr busy", 1'b0, DTR)
      INIT_DONE <= 1'b1;
      expect_byte(8'h02);
      `CHK("rsp gap", 1'b1, n > int'(CHAR_CYCLES))
      expect_byte(RC_READY);
      `CHK("dtr idle", 1'b1, DTR)
      INIT_DONE <= 1'b0;
      host_ack();
   endtask
   // Sense with a jam gives temporary error, then normal once cleared
   task automatic t_sense();
      @(posedge CLK) JAM <= 1'b1;
      send_cmd(8'h02, OP_SENSE);
      expect_byte(8'h03);
      expect_byte(RC_TEMP_ERR);
      expect_byte(8'h01);
      `CHK("rts", 1'b0, RTS)
      JAM <= 1'b0;
      host_ack();
      send_cmd(8'h02, OP_SENSE);
      expect_byte(8'h02);
      expect_byte(RC_NORMAL);
      host_ack();
   endtask
   // Start refused on empty hopper, then start and read; RTS up only for read complete
   task automatic t_read();
      HOPPER_EMPTY <= 1'b1;
      send_cmd(8'h02, OP_START);
      expect_byte(8'h03);
      expect_byte(RC_TEMP_ERR);
      expect_byte(8'h02);
      HOPPER_EMPTY <= 1'b0;
      host_ack();
      send_cmd(8'h02, OP_START);
      expect_byte(8'h02);
      expect_byte(RC_NORMAL);
      `CHK("opcode", OP_START, CMD_OPCODE)
      host_ack();
      send_cmd(8'h02, OP_READ);
      READ_DONE <= 1'b1;
      expect_byte(8'h02);
      `CHK("rts read", 1'b1, RTS)
      READ_DONE <= 1'b0;
      expect_byte(RC_READ_DONE);
      host_ack();
      `CHK("rts idle", 1'b0, RTS)
      `CHK("pulses", 3, pulses)
   endtask
   // Overlong count byte times out and is answered as a transmission error
   task automatic t_bad();
      send_cmd(8'h21, OP_SENSE);
      expect_byte(8'h03);
      expect_byte(RC_OP_ERR);
      expect_byte(DET_XMIT);
      host_ack();
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog at about twice the expected run of some seventy characters
   initial begin
      repeat (80000) @(posedge CLK);
      err_count++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (2) @(posedge CLK);
      t_clear();
      t_sense();
      t_read();
      t_bad();
      conclude();
   end
endmodule
